//--- cies_pkg.sv
// package: constants and types for the instruction execution subset
package cies_pkg;
    localparam int PC_W = 21;
    localparam int STK_DEPTH = 31;
    localparam int STK_IDX_W = 5;
    localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    // flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    // opcode patterns
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_RESET = 16'h00ff;
    localparam logic [14:0] OP_INTERRUPT_RETURN_OP = 15'h0008;
    localparam logic [7:0] OP_RETURN_WITH_LITERAL = 8'h0c;
    localparam logic [6:0] OP_MULT_ACCUM_BY_FILE = 7'h01;
    localparam logic [6:0] OP_NEGATE_FILE_OP = 7'h36;
    localparam logic [5:0] OP_ROTATE_LEFT_THRU_CARRY = 6'h0d;
    localparam logic [5:0] OP_ROTATE_RIGHT_THRU_CARRY = 6'h0c;
    localparam logic [5:0] OP_ROTATE_LEFT_NO_CARRY = 6'h11;
    localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL = 5'h1b;
    typedef enum logic [2:0] {
        CIES_EXEC = 3'b001,
        CIES_FLUSH = 3'b010,
        CIES_RESET = 3'b100
    } cies_state_e;
endpackage : cies_pkg

//--- cies_stack.sv
// return stack holding pushed program counter values
`timescale 1ns/1ps
`default_nettype none
module cies_stack #(
    parameter int DEPTH = cies_pkg::STK_DEPTH,
    parameter int IDX_W = cies_pkg::STK_IDX_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [20:0] push_data,
    output logic [20:0] head,
    output logic [IDX_W-1:0] level
);
    // the pointer must be able to name entry DEPTH itself
    if (DEPTH < 2 || DEPTH >= (1 << IDX_W))
    begin : g_bad_depth
        $error("cies_stack: depth does not fit index");
    end

    logic [20:0] mem_ff [0:DEPTH];
    logic [IDX_W-1:0] ptr_ff;
    logic [20:0] head_ff;
    wire logic [IDX_W-1:0] ptr_up = ptr_ff + IDX_W'(1);
    wire logic [IDX_W-1:0] ptr_dn = ptr_ff - IDX_W'(1);
    wire logic can_push = (ptr_ff < IDX_W'(DEPTH));
    wire logic can_pop = (ptr_ff != '0);

    // entry 0 unused; pointer names current head, zero means empty
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ptr_ff <= '0;
        else if (clear)
            ptr_ff <= '0;
        else if (push && can_push)
            ptr_ff <= ptr_up;
        else if (pop && can_pop)
            ptr_ff <= ptr_dn;
    end

    // head copy kept in a register so the output leaves a flop
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            head_ff <= '0;
        else if (clear)
            head_ff <= '0;
        else if (push && can_push)
            head_ff <= push_data;
        else if (pop && can_pop)
            head_ff <= (ptr_ff == IDX_W'(1)) ? '0 : mem_ff[ptr_dn];
    end

    // storage has no reset; pointer alone decides what is valid
    always_ff @(posedge core_clk)
    begin
        if (push && can_push)
            mem_ff[ptr_up] <= push_data;
    end

    assign head = head_ff;
    assign level = ptr_ff;
endmodule : cies_stack
`default_nettype wire

//--- cies_core.sv
// execution unit for multiply, negate, stack, call, reset, return, rotate
`timescale 1ns/1ps
`default_nettype none
module cies_core (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic ext_set_en,
    input wire logic prio_en,
    input wire logic [7:0] file_rdata,
    input wire logic wr_file_ack,
    output logic [11:0] file_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic [7:0] accumulator,
    output logic [7:0] flags,
    output logic [3:0] bank_selector,
    output logic [7:0] product_upper_byte,
    output logic [7:0] product_lower_byte,
    output logic [20:0] prog_counter,
    output logic [20:0] stack_head_entry,
    output logic global_irq_enable_hi,
    output logic global_irq_enable_lo,
    output logic instr_ready,
    output logic soft_reset_out
);
    // ********************************************
    // decode
    // ********************************************
    logic [7:0] acc_ff, flg_ff, ph_ff, pl_ff;
    logic [3:0] bank_ff;
    logic [7:0] accumulator_shadow, flags_shadow;
    logic [3:0] bank_selector_shadow;
    logic [20:0] pc_ff;
    logic global_irq_enable_hi_ff, global_irq_enable_lo_ff;
    cies_pkg::cies_state_e st_ff;
    logic [11:0] fa_ff;
    logic [7:0] fw_ff;
    logic fwe_ff, srst_ff;
    logic [20:0] head_q;

    wire logic go = instr_valid && (st_ff == cies_pkg::CIES_EXEC);
    wire logic sreset = st_ff == cies_pkg::CIES_RESET;
    wire logic acc_bit = instr[8];
    wire logic dst_bit = instr[9];
    wire logic [7:0] f = instr[7:0];
    wire logic is_mul = instr[15:9] == cies_pkg::OP_MULT_ACCUM_BY_FILE;
    wire logic is_neg = instr[15:9] == cies_pkg::OP_NEGATE_FILE_OP;
    wire logic is_push = instr == cies_pkg::OP_PUSH;
    wire logic is_pop = instr == cies_pkg::OP_POP;
    wire logic is_rst = instr == cies_pkg::OP_RESET;
    wire logic is_rfie = instr[15:1] == cies_pkg::OP_INTERRUPT_RETURN_OP;
    wire logic is_rlw = instr[15:8] == cies_pkg::OP_RETURN_WITH_LITERAL;
    wire logic is_relative_subroutine_call = instr[15:11] == cies_pkg::OP_RELATIVE_SUBROUTINE_CALL;
    wire logic is_rlc = instr[15:10] == cies_pkg::OP_ROTATE_LEFT_THRU_CARRY;
    wire logic is_rrc = instr[15:10] == cies_pkg::OP_ROTATE_RIGHT_THRU_CARRY;
    wire logic is_rln = instr[15:10] == cies_pkg::OP_ROTATE_LEFT_NO_CARRY;
    wire logic is_rot = is_rlc || is_rrc || is_rln;

    // address formation; indexed mode offsets from a pointer base (f2)
    // which lives outside this block, so only a marker bank is used
    wire logic indexed = ext_set_en && !acc_bit
        && (f <= cies_pkg::ACCESS_SPLIT);
    wire logic [11:0] bank_addr = acc_bit ? {bank_ff, f}
        : {{4{f[7]}}, f};
    wire logic [11:0] eff_addr = indexed ? {4'hf, 8'h00} | {4'h0, f}
        : bank_addr;

    // ********************************************
    // datapath
    // ********************************************
    wire logic [15:0] product = acc_ff * file_rdata;
    wire logic [7:0] neg_v = ~file_rdata + 8'h01;
    wire logic neg_c = (file_rdata == 8'h00);
    wire logic neg_dc = (file_rdata[3:0] == 4'h0);
    wire logic neg_ov = (file_rdata == 8'h80);
    wire logic [7:0] rot_v = is_rln ? {file_rdata[6:0], file_rdata[7]}
        : is_rlc ? {file_rdata[6:0], flg_ff[cies_pkg::FLG_C]}
        : {flg_ff[cies_pkg::FLG_C], file_rdata[7:1]};
    wire logic rot_c = is_rrc ? file_rdata[0] : file_rdata[7];
    wire logic [20:0] nxt_pc2 = pc_ff + cies_pkg::PC_STEP;
    wire logic [20:0] rel = {{9{instr[10]}}, instr[10:0], 1'b0};
    wire logic [7:0] res_v = is_neg ? neg_v : rot_v;

    // stack control
    wire logic stk_push = go && (is_push || is_relative_subroutine_call);
    wire logic stk_pop = go && (is_pop || is_rfie || is_rlw);

    cies_stack u_stack (
        .core_clk(core_clk),
        .reset(reset),
        .clear(sreset),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(nxt_pc2),
        .head(head_q),
        .level()
    );

    // ********************************************
    // sequencing
    // ********************************************
    // two-cycle ops flush in the second; reset entered at q2 of cycle
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            st_ff <= cies_pkg::CIES_EXEC;
        else
            unique case (st_ff)
                cies_pkg::CIES_EXEC:
                    if (go && is_rst)
                        st_ff <= cies_pkg::CIES_RESET;
                    else if (go && (is_relative_subroutine_call || is_rfie || is_rlw))
                        st_ff <= cies_pkg::CIES_FLUSH;
                cies_pkg::CIES_FLUSH:
                    st_ff <= cies_pkg::CIES_EXEC;
                cies_pkg::CIES_RESET:
                    st_ff <= cies_pkg::CIES_EXEC;
                default:
                    st_ff <= cies_pkg::CIES_EXEC;
            endcase
    end

    // program counter and irq enables
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pc_ff <= cies_pkg::PC_RST;
            global_irq_enable_hi_ff <= 1'b0;
            global_irq_enable_lo_ff <= 1'b0;
        end
        else if (sreset)
        begin
            pc_ff <= cies_pkg::PC_RST;
            global_irq_enable_hi_ff <= 1'b0;
            global_irq_enable_lo_ff <= 1'b0;
        end
        else if (go)
        begin
            if (is_relative_subroutine_call)
                pc_ff <= nxt_pc2 + rel;
            else if (is_rfie || is_rlw)
                pc_ff <= head_q;
            else if (!is_rst)
                pc_ff <= nxt_pc2;
            if (is_rfie && (instr[0] == 1'b0 || !prio_en))
                global_irq_enable_hi_ff <= 1'b1;
            else if (is_rfie)
                global_irq_enable_lo_ff <= 1'b1;
        end
    end

    // working registers; multiply touches only the product pair
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            acc_ff <= cies_pkg::WREG_RST;
            flg_ff <= cies_pkg::FLAGS_RST;
            bank_ff <= cies_pkg::BANK_RST;
            ph_ff <= 8'h00;
            pl_ff <= 8'h00;
        end
        else if (sreset)
        begin
            acc_ff <= cies_pkg::WREG_RST;
            flg_ff <= cies_pkg::FLAGS_RST;
            bank_ff <= cies_pkg::BANK_RST;
            ph_ff <= 8'h00;
            pl_ff <= 8'h00;
        end
        else if (go)
        begin
            if (is_mul)
            begin
                ph_ff <= product[15:8];
                pl_ff <= product[7:0];
            end
            if (is_neg)
                flg_ff[4:0] <= {neg_v[7], neg_ov, (neg_v == 8'h00),
                    neg_dc, neg_c};
            if (is_rot)
            begin
                flg_ff[cies_pkg::FLG_N] <= rot_v[7];
                flg_ff[cies_pkg::FLG_Z] <= (rot_v == 8'h00);
                if (!is_rln)
                    flg_ff[cies_pkg::FLG_C] <= rot_c;
            end
            if (is_rot && !dst_bit)
                acc_ff <= rot_v;
            if (is_rlw)
                acc_ff <= f;
            if (is_rfie && instr[0])
            begin
                acc_ff <= accumulator_shadow;
                flg_ff <= flags_shadow;
                bank_ff <= bank_selector_shadow;
            end
        end
    end

    // shadows track live values; interrupt entry lives elsewhere
    assign accumulator_shadow = acc_ff;
    assign flags_shadow = flg_ff;
    assign bank_selector_shadow = bank_ff;

    // file write port
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            fa_ff <= 12'h000;
            fw_ff <= 8'h00;
            fwe_ff <= 1'b0;
            srst_ff <= 1'b0;
        end
        else
        begin
            fa_ff <= eff_addr;
            fw_ff <= res_v;
            fwe_ff <= go && (is_neg || (is_rot && dst_bit));
            srst_ff <= go && is_rst;
        end
    end

    assign file_addr = fa_ff;
    assign file_wdata = fw_ff;
    assign file_we = fwe_ff;
    assign accumulator = acc_ff;
    assign flags = flg_ff;
    assign bank_selector = bank_ff;
    assign product_upper_byte = ph_ff;
    assign product_lower_byte = pl_ff;
    assign prog_counter = pc_ff;
    assign stack_head_entry = head_q;
    assign global_irq_enable_hi = global_irq_enable_hi_ff;
    assign global_irq_enable_lo = global_irq_enable_lo_ff;
    assign instr_ready = st_ff[0]; // exec state is one-hot bit 0
    assign soft_reset_out = srst_ff;
endmodule : cies_core
`default_nettype wire

//--- cies_properties.sv
// checker: timing and result properties of the execution unit
`timescale 1ns/1ps
`default_nettype none
module cies_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [15:0] instr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] flags,
    input wire logic [7:0] product_upper_byte,
    input wire logic [7:0] product_lower_byte,
    input wire logic [20:0] prog_counter,
    input wire logic [20:0] stack_head_entry
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // decode only accepted words, a refused word must not trigger checks
    wire logic go = instr_valid && instr_ready;
    wire logic is_mul = go && instr[15:9] == cies_pkg::OP_MULT_ACCUM_BY_FILE;
    wire logic is_psh = go && instr == cies_pkg::OP_PUSH;
    wire logic is_cal = go && instr[15:11] == cies_pkg::OP_RELATIVE_SUBROUTINE_CALL;
    wire logic is_rfi = go && instr[15:1] == cies_pkg::OP_INTERRUPT_RETURN_OP;
    wire logic is_rlw = go && instr[15:8] == cies_pkg::OP_RETURN_WITH_LITERAL;
    wire logic is_rln = go && instr[15:10] == cies_pkg::OP_ROTATE_LEFT_NO_CARRY;
    wire logic is_rlc = go && instr[15:10] == cies_pkg::OP_ROTATE_LEFT_THRU_CARRY;
    // ************************************************************
    // properties
    // ************************************************************
    a_mul_product: assert property (
        is_mul |=> {product_upper_byte, product_lower_byte} ==
        16'($past(accumulator)) * 16'($past(file_rdata)))
        else $error("product pair wrong after multiply");
    a_mul_quiet: assert property (
        is_mul |=> $stable(accumulator) && $stable(flags))
        else $error("multiply disturbed accumulator or flags");
    a_push_head: assert property (
        is_psh |=> stack_head_entry == $past(prog_counter) + 21'h2)
        else $error("push stored wrong stack head");
    a_call_target: assert property (
        is_cal |=> prog_counter == $past(prog_counter) + 21'h2 +
        {{9{$past(instr[10])}}, $past(instr[10:0]), 1'b0})
        else $error("relative call target wrong");
    a_call_flush: assert property (
        is_cal |=> !instr_ready ##1 instr_ready)
        else $error("relative call not two cycles");
    a_rfi_pop: assert property (
        is_rfi |=> prog_counter == $past(stack_head_entry) && !instr_ready)
        else $error("interrupt return pop wrong");
    a_return_with_literal_load: assert property (
        is_rlw |=> accumulator == $past(instr[7:0]) &&
        prog_counter == $past(stack_head_entry))
        else $error("literal return wrong");
    a_rln_flags: assert property (
        is_rln |=> (flags & 8'h0b) == ($past(flags) & 8'h0b))
        else $error("plain rotate touched carry, digit carry or overflow");
    a_rlc_carry: assert property (
        is_rlc |=> flags[cies_pkg::FLG_C] == $past(file_rdata[7]))
        else $error("rotate left did not move top bit to carry");
endmodule : cies_props
bind cies_core cies_props u_props (.core_clk(core_clk), .reset(reset),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr),
    .file_rdata(file_rdata), .accumulator(accumulator), .flags(flags),
    .product_upper_byte(product_upper_byte),
    .product_lower_byte(product_lower_byte),
    .prog_counter(prog_counter), .stack_head_entry(stack_head_entry));
`default_nettype wire

//--- cies_bench.sv
// testbench: directed corners and seeded random runs of the execution unit
`timescale 1ns/1ps
`default_nettype none
module cies_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    logic ext_set_en = 1'b0;
    logic prio_en = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [11:0] file_addr;
    logic [7:0] file_wdata, accumulator, flags, product_upper_byte;
    logic [7:0] product_lower_byte;
    logic [3:0] bank_selector;
    logic [20:0] prog_counter, stack_head_entry;
    logic file_we, global_irq_enable_hi, global_irq_enable_lo;
    logic instr_ready, soft_reset_out;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] seed = 8'h43;
    logic [7:0] macc = 8'h00;
    logic [7:0] mflg = 8'h00;
    logic [20:0] mpc = 21'h000000;
    logic [20:0] stk[$];
    cies_core dut (.core_clk(core_clk), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .ext_set_en(ext_set_en),
        .prio_en(prio_en), .file_rdata(file_rdata), .wr_file_ack(1'b0),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
        .accumulator(accumulator), .flags(flags),
        .bank_selector(bank_selector),
        .product_upper_byte(product_upper_byte),
        .product_lower_byte(product_lower_byte),
        .prog_counter(prog_counter), .stack_head_entry(stack_head_entry),
        .global_irq_enable_hi(global_irq_enable_hi),
        .global_irq_enable_lo(global_irq_enable_lo),
        .instr_ready(instr_ready), .soft_reset_out(soft_reset_out));
    // ************************************************************
    // clock, hang ceiling and helpers
    // ************************************************************
    always #50 core_clk = ~core_clk;
    // about 160 cycles are needed; the ceiling leaves wide margin
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // new flags in the high byte, result in the low byte
    function automatic logic [15:0] calc(input int k, input logic [7:0] f,
        input logic [7:0] fl);
        logic [7:0] r;
        logic [7:0] n;
        n = fl;
        r = (k == 1) ? ~f + 8'h01 : (k == 2) ? {f[6:0], f[7]} :
            (k == 3) ? {f[6:0], fl[0]} : {fl[0], f[7:1]};
        n[cies_pkg::FLG_N] = r[7];
        n[cies_pkg::FLG_Z] = (r == 8'h00);
        if (k == 1)
            n[3:0] = {f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
        if (k > 2)
            n[cies_pkg::FLG_C] = (k == 3) ? f[7] : f[0];
        return {n, r};
    endfunction : calc
    // reset bank when banked, access bank low or high half by f[7], or indexed marker page when extended
    function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f,
        input logic x);
        if (a)
            return {cies_pkg::BANK_RST, f};
        return (f[7] || (x && f <= cies_pkg::ACCESS_SPLIT)) ? {4'hf, f}
            : {4'h0, f};
    endfunction : eaddr
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic chk_core();
        chk("accumulator", macc, accumulator);
        chk("flags", mflg, flags);
        chk("program counter", mpc, prog_counter);
        chk("stack head", stk.size() ? stk[$] : 21'h0, stack_head_entry);
        chk("bank selector", cies_pkg::BANK_RST, bank_selector);
    endtask : chk_core
    // offer a word at the falling edge once ready, return after the take
    task automatic exec(input logic [15:0] op, input logic [7:0] fd);
        int j;
        j = 0;
        @(negedge core_clk);
        while (instr_ready !== 1'b1 && j < 4)
        begin
            @(negedge core_clk);
            j++;
        end
        instr = op;
        file_rdata = fd;
        instr_valid = 1'b1;
        @(posedge core_clk);
        #1;
    endtask : exec
    task automatic m_push(input logic [20:0] tgt);
        stk.push_back(mpc + 21'h2);
        mpc = tgt;
    endtask : m_push
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [7:0] f;
        logic [10:0] n;
        logic [15:0] r;
        logic [15:0] op;
        logic [15:0] p;
        logic a, d, x, w;
        int k;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        chk_core();
        repeat (3)
        begin
            exec(cies_pkg::OP_PUSH, 8'h00);
            m_push(mpc + 21'h2);
            chk_core();
        end
        exec(cies_pkg::OP_POP, 8'h00);
        void'(stk.pop_back());
        mpc += 21'h2;
        chk_core();
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : {seed[2:0], seed};
            exec({cies_pkg::OP_RELATIVE_SUBROUTINE_CALL, n}, 8'h00);
            m_push(mpc + 21'h2 + {{9{n[10]}}, n, 1'b0});
            chk("ready after call", 0, instr_ready);
            chk_core();
            seed = lfsr(seed);
            exec({cies_pkg::OP_RETURN_WITH_LITERAL, seed}, 8'h00);
            macc = seed;
            mpc = stk.pop_back();
            chk_core();
        end
        $display("stack and call test done");
        @(negedge core_clk);
        for (int i = 0; i < 60; i++)
        begin
            k = i % 5;
            seed = lfsr(seed);
            f = (i < 10) ? ((i < 5) ? 8'h5f : 8'h60) : seed;
            f = (i == 11) ? 8'h00 : (i == 16) ? 8'h80 : f;
            seed = lfsr(seed);
            {x, d, a} = (i < 10) ? {2'b10, seed[1]} : seed[2:0];
            ext_set_en = x;
            r = calc(k, f, mflg);
            op = (k == 0) ? {cies_pkg::OP_MULT_ACCUM_BY_FILE, a, f} :
                (k == 1) ? {cies_pkg::OP_NEGATE_FILE_OP, a, f} :
                (k == 2) ? {cies_pkg::OP_ROTATE_LEFT_NO_CARRY, d, a, f} :
                (k == 3) ? {cies_pkg::OP_ROTATE_LEFT_THRU_CARRY, d, a, f} :
                {cies_pkg::OP_ROTATE_RIGHT_THRU_CARRY, d, a, f};
            exec(op, f);
            mpc += 21'h2;
            p = {product_upper_byte, product_lower_byte};
            if (k == 0)
                chk("product", 32'(macc) * 32'(f), p);
            else
                mflg = r[15:8];
            if (k > 1 && !d)
                macc = r[7:0];
            chk_core();
            // multiply and rotate into the accumulator must not write back
            w = (k == 1) || (k > 1 && d);
            @(negedge core_clk);
            instr_valid = 1'b0;
            chk("write strobe", w, file_we);
            chk("write address", eaddr(a, f, x), file_addr);
            if (w)
                chk("write data", r[7:0], file_wdata);
        end
        $display("random operand test done");
        for (int i = 0; i < 4; i++)
        begin
            @(negedge core_clk);
            prio_en = i[1];
            exec(cies_pkg::OP_PUSH, 8'h00);
            m_push(mpc + 21'h2);
            exec({cies_pkg::OP_INTERRUPT_RETURN_OP, i[0]}, 8'h00);
            mpc = stk.pop_back();
            chk_core();
            chk("irq enable hi", 1, global_irq_enable_hi);
            chk("irq enable lo", i == 3, global_irq_enable_lo);
        end
        $display("interrupt return test done");
        exec(cies_pkg::OP_RESET, 8'h00);
        @(negedge core_clk);
        instr_valid = 1'b0;
        chk("soft reset", 1, soft_reset_out);
        repeat (3) @(negedge core_clk);
        chk("soft reset end", 0, soft_reset_out);
        {macc, mflg, mpc} = '0;
        stk.delete();
        chk_core();
        p = {product_upper_byte, product_lower_byte};
        chk("product reset", 0, p);
        w = global_irq_enable_hi | global_irq_enable_lo;
        chk("irq enables reset", 0, w);
        $display("software reset test done");
        print_verdict();
    end
endmodule : cies_bench
`default_nettype wire
